// ---- fslm_top.sv ----
// Frame-sync lock detection, monitor outputs and register slave.
`timescale 1ns/10ps

// Function
// R1: Sample frame_sync_good at 460Hz; a high sample drives lock indicator high.
// R2: Lock indicator goes low only after eight successive low samples.
// R3: indicator_pin_input_select high releases the lock pin and reads it.
// R4: spindle_filter_switch carries protected_subcode_sync when select bit set.
// R5: 64-bit monitor slot shifts LSB first, two's complement.
// R6: 48-bit monitor slot shifts MSB first, two's complement.
// R7: sync_window_released_flag high while protection window is released.
// R8: raw_frame_sync_n is the unprotected detected frame sync, low pulse.
// R9: inverted_bit_clock is the inverse of the EFM PLL bit clock.
// R10: frame_sync_good only when detected sync matches expected timing.
// R11: read_frame_tick comes from the crystal clock with 136us period.
// R12: data_error_flag shows error status of the data now output.
// R13: buffer_overflow_n asserts when jitter exceeds plus or minus 28 frames.
// R14: Outside system holds variable_pitch_clock_in low when undriven.
// R15: Low-sample count clears on a high sample and on reset.
module fslm_top #(
  parameter int LOCK_SAMPLE_CYC = fslm_pkg::LOCK_SAMPLE_CYC,
  parameter int FRAME_CYC = fslm_pkg::FRAME_CYC
) (
  input wire logic clk_i, // 100 MHz system clock.
  input wire logic rst_b_i, // System reset, active low, asynchronous.
  input wire logic [3:0] avs_address_i, // Avalon byte address.
  input wire logic avs_read_i, // Avalon read request.
  input wire logic avs_write_i, // Avalon write request.
  input wire logic [31:0] avs_writedata_i, // Avalon write data.
  output logic [31:0] avs_readdata_o, // Avalon read data.
  output logic avs_waitrequest_o, // Avalon wait request.
  input wire logic efm_sync_det_i, // Sync pattern seen in EFM, pulse.
  input wire logic bit_clk_i, // EFM PLL bit clock, other domain.
  input wire logic lock_pin_i, // Level seen on the lock pin.
  output logic lock_pin_o, // Lock indicator drive.
  output logic lock_pin_oe_o, // Lock pin output enable.
  input wire logic protected_subcode_sync_i, // Protected subcode sync.
  input wire logic spindle_filter_i, // Spindle filter switching level.
  output logic spindle_filter_switch_o, // Filter switch pin drive.
  output logic spindle_filter_switch_oe_o, // Filter switch pin enable.
  input wire logic [63:0] slot_a_data_i, // 64-bit slot, two's complement.
  input wire logic [47:0] slot_b_data_i, // 48-bit slot, two's complement.
  input wire logic slot_load_i, // Capture both slots, pulse.
  input wire logic slot_shift_i, // Advance serial monitor, pulse.
  output logic slot_sd_o, // Serial monitor data.
  output logic sync_window_released_flag_o, // Protection released.
  output logic raw_frame_sync_n_o, // Unprotected frame sync, low pulse.
  output logic inverted_bit_clock_o, // Inverse of the bit clock.
  output logic read_frame_tick_o, // Crystal frame clock.
  input wire logic data_error_i, // Error status of current data.
  output logic data_error_flag_o, // Error status flag.
  input wire logic signed [7:0] jitter_frames_i, // Buffer jitter, frames.
  output logic buffer_overflow_n_o // Low while jitter margin exceeded.
);

  // ---------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Release is synchronised so every flop leaves reset on one edge.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic [1:0] pins_sync;

  fslm_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .async_i({lock_pin_i, bit_clk_i}),
    .sync_o(pins_sync)
  );

  logic bit_clk_s;
  logic lock_pin_s;
  assign bit_clk_s = pins_sync[0];
  assign lock_pin_s = pins_sync[1];

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic pin_input_sel;
  logic subcode_sync_output_select;
  logic bus_take;

  // A request is served on the edge where waitrequest is seen low.
  assign bus_take = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_input_sel <= fslm_pkg::CTRL_RESET[fslm_pkg::CTRL_PIN_SEL_BIT];
      subcode_sync_output_select <= fslm_pkg::CTRL_RESET[fslm_pkg::CTRL_SUBCODE_SYNC_OUTPUT_SELECT_BIT];
    end else if (bus_take && avs_write_i &&
                 avs_address_i == fslm_pkg::CTRL_OFS) begin
      pin_input_sel <= avs_writedata_i[fslm_pkg::CTRL_PIN_SEL_BIT];
      subcode_sync_output_select <= avs_writedata_i[fslm_pkg::CTRL_SUBCODE_SYNC_OUTPUT_SELECT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Frame sync insertion protection
  // ---------------------------------------------------------------
  localparam int CW = $clog2(FRAME_CYC + 1);
  localparam logic [CW-1:0] FRAME_LAST = CW'(FRAME_CYC - 1);
  localparam logic [CW-1:0] TOL = CW'(fslm_pkg::SYNC_TOL_CYC);
  localparam logic [1:0] MISS_LIMIT = 2'(fslm_pkg::SYNC_MISS_LIMIT);

  logic [CW-1:0] frame_cnt;
  logic in_window;
  logic window_hit;
  logic hit_seen;
  logic [1:0] miss_cnt;
  logic released;
  logic good;

  // The window spans the expected position, wrapping over zero.
  assign in_window = (frame_cnt >= FRAME_LAST - TOL) || (frame_cnt <= TOL);
  assign window_hit = efm_sync_det_i & in_window;

  // Counter realigns on an accepted sync; a released window takes any.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt <= '0;
    end else if ((released && efm_sync_det_i) || (!released && window_hit &&
                 !hit_seen)) begin
      frame_cnt <= '0;
    end else if (frame_cnt == FRAME_LAST) begin
      frame_cnt <= '0;
    end else begin
      frame_cnt <= frame_cnt + 1'b1;
    end
  end

  // One hit per window; the flag drops once the window has closed.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hit_seen <= 1'b0;
    end else if (released) begin
      hit_seen <= efm_sync_det_i;
    end else if (window_hit) begin
      hit_seen <= 1'b1;
    end else if (frame_cnt == TOL + 1'b1) begin
      hit_seen <= 1'b0;
    end
  end

  // Good follows each window outcome; misses in a row release it.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      good <= 1'b0;
      miss_cnt <= '0;
      released <= 1'b1;
    end else if (released) begin
      good <= 1'b0;
      miss_cnt <= '0;
      released <= ~efm_sync_det_i; // R7
    end else if (window_hit) begin
      good <= 1'b1; // R10
      miss_cnt <= '0;
    end else if (frame_cnt == TOL && !hit_seen) begin
      good <= 1'b0; // R10
      miss_cnt <= miss_cnt + 1'b1;
      released <= (miss_cnt + 1'b1 == MISS_LIMIT); // R7
    end
  end

  // ---------------------------------------------------------------
  // Lock indicator
  // ---------------------------------------------------------------
  localparam int SW = $clog2(LOCK_SAMPLE_CYC + 1);
  localparam logic [SW-1:0] SAMPLE_LAST = SW'(LOCK_SAMPLE_CYC - 1);
  localparam logic [3:0] LOW_LAST = 4'(fslm_pkg::LOCK_LOW_SAMPLES - 1);

  logic [SW-1:0] sample_cnt;
  logic sample_now;
  logic [3:0] low_cnt;
  logic lock;

  assign sample_now = (sample_cnt == SAMPLE_LAST);

  // Free running sampler, independent of the disc.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sample_cnt <= '0;
    end else if (sample_now) begin
      sample_cnt <= '0; // R1
    end else begin
      sample_cnt <= sample_cnt + 1'b1;
    end
  end

  // A single good sample locks; only a full run of lows unlocks.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lock <= 1'b0;
      low_cnt <= '0; // R15
    end else if (sample_now) begin
      if (good) begin
        lock <= 1'b1; // R1
        low_cnt <= '0; // R15
      end else if (low_cnt == LOW_LAST) begin
        lock <= 1'b0; // R2
      end else begin
        low_cnt <= low_cnt + 1'b1; // R2
      end
    end
  end

  // The pin is released when software turns it into an input.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_pin_o <= 1'b0;
      lock_pin_oe_o <= 1'b0;
    end else begin
      lock_pin_o <= lock;
      lock_pin_oe_o <= ~pin_input_sel; // R3
    end
  end

  // ---------------------------------------------------------------
  // Filter switch pin
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spindle_filter_switch_o <= 1'b0;
      spindle_filter_switch_oe_o <= 1'b0;
    end else begin
      spindle_filter_switch_o <= subcode_sync_output_select ? protected_subcode_sync_i
                                          : spindle_filter_i; // R4
      spindle_filter_switch_oe_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Serial monitor slots
  // ---------------------------------------------------------------
  localparam int TOTAL_BITS = fslm_pkg::SLOT_A_BITS + fslm_pkg::SLOT_B_BITS;
  localparam logic [6:0] A_BITS = 7'(fslm_pkg::SLOT_A_BITS);
  localparam logic [6:0] LAST_BIT = 7'(TOTAL_BITS - 1);

  logic [63:0] slot_a;
  logic [47:0] slot_b;
  logic [6:0] bit_idx;
  logic shifting;

  // Slot A goes out LSB first, slot B MSB first; values are as captured.
  function automatic logic slot_bit(input logic [63:0] a,
                                    input logic [47:0] b,
                                    input logic [6:0] idx);
    logic [6:0] b_idx;
    b_idx = 7'(fslm_pkg::SLOT_B_BITS - 1) - (idx - A_BITS);
    if (idx < A_BITS) begin
      slot_bit = a[idx[5:0]]; // R5
    end else begin
      slot_bit = b[b_idx[5:0]]; // R6
    end
  endfunction

  // A new load restarts the stream even in the middle of a frame.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      slot_a <= '0;
      slot_b <= '0;
      bit_idx <= '0;
      shifting <= 1'b0;
      slot_sd_o <= 1'b0;
    end else if (slot_load_i) begin
      slot_a <= slot_a_data_i;
      slot_b <= slot_b_data_i;
      bit_idx <= '0;
      shifting <= 1'b1;
      slot_sd_o <= slot_a_data_i[0]; // R5
    end else if (slot_shift_i && shifting) begin
      bit_idx <= (bit_idx == LAST_BIT) ? bit_idx : bit_idx + 1'b1;
      shifting <= (bit_idx != LAST_BIT);
      slot_sd_o <= (bit_idx == LAST_BIT) ? 1'b0
                   : slot_bit(slot_a, slot_b, bit_idx + 1'b1);
    end
  end

  // ---------------------------------------------------------------
  // Monitor outputs
  // ---------------------------------------------------------------
  localparam logic [CW-1:0] HALF_FRAME = CW'(FRAME_CYC / 2);
  localparam logic signed [7:0] MARGIN = 8'(fslm_pkg::JITTER_MARGIN_FRAMES);

  logic [CW-1:0] tick_cnt;

  // The tick runs from the crystal so disc jitter never moves it.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
    end else if (tick_cnt == FRAME_LAST) begin
      tick_cnt <= '0; // R11
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // Registered outputs: decoded tick and overflow flag, plain or inverted copies for the rest; the bit clock lags by the synchroniser.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      read_frame_tick_o <= 1'b0;
      raw_frame_sync_n_o <= 1'b1;
      inverted_bit_clock_o <= 1'b1;
      sync_window_released_flag_o <= 1'b1;
      data_error_flag_o <= 1'b0;
      buffer_overflow_n_o <= 1'b1;
    end else begin
      read_frame_tick_o <= (tick_cnt < HALF_FRAME); // R11
      raw_frame_sync_n_o <= ~efm_sync_det_i; // R8
      inverted_bit_clock_o <= ~bit_clk_s; // R9
      sync_window_released_flag_o <= released; // R7
      data_error_flag_o <= data_error_i; // R12
      buffer_overflow_n_o <= ~(jitter_frames_i > MARGIN ||
                               jitter_frames_i < -MARGIN); // R13
    end
  end

  // ---------------------------------------------------------------
  // Avalon slave: one wait state, then a one-cycle answer
  // ---------------------------------------------------------------
  logic [31:0] next_readdata;

  always_comb begin
    next_readdata = '0;
    unique case (avs_address_i)
      fslm_pkg::CTRL_OFS: begin
        next_readdata[fslm_pkg::CTRL_PIN_SEL_BIT] = pin_input_sel;
        next_readdata[fslm_pkg::CTRL_SUBCODE_SYNC_OUTPUT_SELECT_BIT] = subcode_sync_output_select;
      end
      fslm_pkg::STATUS_OFS: begin
        next_readdata[fslm_pkg::ST_LOCK_BIT] = lock;
        next_readdata[fslm_pkg::ST_LOCK_PIN_BIT] = lock_pin_s; // R3
        next_readdata[fslm_pkg::ST_GOOD_BIT] = good;
        next_readdata[fslm_pkg::ST_WIN_BIT] = released;
        next_readdata[fslm_pkg::ST_OVF_BIT] = ~buffer_overflow_n_o;
      end
      fslm_pkg::LOWCNT_OFS: begin
        next_readdata[3:0] = low_cnt;
      end
      default: begin
        next_readdata = '0;
      end
    endcase
  end

  // Waitrequest drops for one cycle per request, so each is served once.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      avs_readdata_o <= avs_read_i ? next_readdata : '0;
    end
  end

endmodule

// ---- fslm_pkg.sv ----
// Package of constants for the frame-sync lock monitor.
package fslm_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCK_SAMPLE_HZ = 460;
  localparam int LOCK_SAMPLE_NS = 1000000000 / LOCK_SAMPLE_HZ;
  localparam int LOCK_SAMPLE_CYC = LOCK_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int FRAME_PERIOD_NS = 136000;
  localparam int FRAME_CYC = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LOCK_LOW_SAMPLES = 8;
  localparam int JITTER_MARGIN_FRAMES = 28;
  localparam int SYNC_TOL_CYC = 4;
  localparam int SYNC_MISS_LIMIT = 3;

  // ---------------------------------------------------------------
  // Monitor slot widths
  // ---------------------------------------------------------------
  localparam int SLOT_A_BITS = 64;
  localparam int SLOT_B_BITS = 48;

  // ---------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] LOWCNT_OFS = 4'h8;
  localparam int CTRL_PIN_SEL_BIT = 0;
  localparam int CTRL_SUBCODE_SYNC_OUTPUT_SELECT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_LOCK_PIN_BIT = 1;
  localparam int ST_GOOD_BIT = 2;
  localparam int ST_WIN_BIT = 3;
  localparam int ST_OVF_BIT = 4;

endpackage

// ---- fslm_sync.sv ----
// Two-stage synchroniser for levels that arrive from outside the clock.
`timescale 1ns/10ps
module fslm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Synchronised reset, active low.
  input wire logic [WIDTH-1:0] async_i, // Asynchronous inputs.
  output logic [WIDTH-1:0] sync_o // Synchronised copies.
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second; nothing else looks at it.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// ---- fslm_asserts.sv ----
// Port-level checks for the frame-sync lock monitor.
`timescale 1ns/10ps
module fslm_asserts #(
  parameter int FRAME_CYC = 40
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_b_i, // Reset, low.
  input wire logic [3:0] avs_address_i, // Address.
  input wire logic avs_read_i, // Read.
  input wire logic avs_write_i, // Write.
  input wire logic [31:0] avs_writedata_i, // Write data.
  input wire logic avs_waitrequest_o, // Wait.
  input wire logic efm_sync_det_i, // Sync seen.
  input wire logic bit_clk_i, // Bit clock.
  input wire logic lock_pin_oe_o, // Lock enable.
  input wire logic protected_subcode_sync_i, // Subcode sync.
  input wire logic spindle_filter_i, // Filter level.
  input wire logic spindle_filter_switch_o, // Filter pin.
  input wire logic spindle_filter_switch_oe_o, // Filter enable.
  input wire logic sync_window_released_flag_o, // Released.
  input wire logic raw_frame_sync_n_o, // Raw sync.
  input wire logic inverted_bit_clock_o, // Inverse clock.
  input wire logic read_frame_tick_o, // Frame tick.
  input wire logic data_error_i, // Error in.
  input wire logic data_error_flag_o, // Error out.
  input wire logic signed [7:0] jitter_frames_i, // Jitter.
  input wire logic buffer_overflow_n_o // Overflow.
);
  logic [2:0] live_cnt;
  logic [1:0] ctrl_sh;
  logic [15:0] tick_cnt;
  logic tick_d, tick_seen, live, fsw_exp, jit_ok, tick_rise;
  assign live = live_cnt == 3'h4;
  assign fsw_exp = ctrl_sh[1] ? protected_subcode_sync_i : spindle_filter_i;
  assign jit_ok = jitter_frames_i <= 8'sd28 && jitter_frames_i >= -8'sd28;
  assign tick_rise = read_frame_tick_o && !tick_d;
  // Outputs are only judged once the synchronised reset has let go.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      live_cnt <= 3'h0;
      ctrl_sh <= 2'h0;
      tick_d <= 1'b0;
      tick_seen <= 1'b0;
      tick_cnt <= 16'h0;
    end else begin
      live_cnt <= live ? live_cnt : live_cnt + 3'h1;
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0) begin
        ctrl_sh <= avs_writedata_i[1:0];
      end
      tick_d <= read_frame_tick_o;
      tick_seen <= tick_seen || tick_rise;
      tick_cnt <= tick_rise ? 16'h1 : tick_cnt + 16'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && live;
  endsequence
  sequence s_ans;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  a_bus_answer_once: assert property (s_req |=> s_ans)
    else $error("bus answer late or too long");
  a_raw_sync_low: assert property (
    live |=> raw_frame_sync_n_o == !$past(efm_sync_det_i))
    else $error("raw frame sync pulse wrong");
  a_bit_clk_inverse: assert property (
    (live && $stable(bit_clk_i)) [*8] |-> inverted_bit_clock_o == !bit_clk_i)
    else $error("inverted bit clock wrong");
  a_err_flag_copy: assert property (
    live |=> data_error_flag_o == $past(data_error_i))
    else $error("error flag wrong");
  a_overflow_margin: assert property (
    live |=> buffer_overflow_n_o == $past(jit_ok))
    else $error("overflow flag wrong");
  a_filter_pin_select: assert property (
    live |=> spindle_filter_switch_o == $past(fsw_exp))
    else $error("filter switch pin wrong");
  a_filter_pin_driven: assert property (
    live |-> spindle_filter_switch_oe_o)
    else $error("filter switch pin not driven");
  a_lock_pin_release: assert property (
    live |=> lock_pin_oe_o == !$past(ctrl_sh[0]))
    else $error("lock pin enable wrong");
  a_window_closes: assert property (
    live && efm_sync_det_i |-> ##[1:3] !sync_window_released_flag_o)
    else $error("window still released after sync");
  a_tick_period: assert property (
    tick_rise && tick_seen |-> tick_cnt == FRAME_CYC)
    else $error("frame tick period wrong");
endmodule

bind fslm_top fslm_asserts #(.FRAME_CYC(FRAME_CYC)) u_chk (.*);

// ---- fslm_far_model.sv ----
// Far side: EFM sync source, PLL bit clock and the lock-pin wire.
`timescale 1ns/10ps
module fslm_far_model #(
  parameter int FRAME_CYC = 40
) (
  input wire logic clk_i, // Clock.
  input wire logic en_i, // Emit frame syncs.
  input wire logic drv_i, // Lock drive from the block.
  input wire logic oe_i, // Lock enable from the block.
  input wire logic ext_i, // Outside circuit level.
  output logic sync_o, // Frame sync pulse.
  output logic bit_clk_o, // PLL bit clock.
  output logic pin_o, // Resolved lock pin.
  output logic vpc_o // Variable pitch clock.
);
  int cnt = 0;
  // One sync per frame while the disc is readable.
  initial sync_o = 1'b0;
  always @(posedge clk_i) begin
    cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
    sync_o <= en_i && cnt == FRAME_CYC - 1;
  end
  // Slow and unrelated in phase, so the synchroniser sees each level.
  initial begin
    bit_clk_o = 1'b0;
    forever #113 bit_clk_o = !bit_clk_o;
  end
  // The outside circuit drives the pin whenever the block lets go.
  assign pin_o = oe_i ? drv_i : ext_i;
  // No external oscillator is fitted, so the input is held low.
  assign vpc_o = 1'b0;
endmodule

// ---- tb_frame_sync_lock_monitor.sv ----
// Self-checking bench for the frame-sync lock monitor.
`timescale 1ns/10ps
module tb_frame_sync_lock_monitor;
  localparam int LSC = 50;
  localparam int FC = 40;
  logic clk, rst_b, rd, wr, wreq, sync_det, bclk, pin_lvl, lock_o, lock_oe;
  logic psync, sfil, spindle_filter_switch, fsw_oe, load, shift, sd, rel, raw_n, inv_clk;
  logic tick, err_in, err_flag, ovf_n, en, ext;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [63:0] slot_a;
  logic [47:0] slot_b;
  logic signed [7:0] jit;
  logic signed [7:0] edges [8] = '{28, 29, -28, -29, 0, 127, -128, 1};
  int seed = 32'h2506;
  int miscompares = 0;
  int samples_checked = 0;
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  fslm_top #(.LOCK_SAMPLE_CYC(LSC), .FRAME_CYC(FC)) u_dut (
    .clk_i(clk), .rst_b_i(rst_b), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .efm_sync_det_i(sync_det),
    .bit_clk_i(bclk), .lock_pin_i(pin_lvl), .lock_pin_o(lock_o),
    .lock_pin_oe_o(lock_oe), .protected_subcode_sync_i(psync),
    .spindle_filter_i(sfil), .spindle_filter_switch_o(spindle_filter_switch),
    .spindle_filter_switch_oe_o(fsw_oe), .slot_a_data_i(slot_a),
    .slot_b_data_i(slot_b), .slot_load_i(load), .slot_shift_i(shift),
    .slot_sd_o(sd), .sync_window_released_flag_o(rel),
    .raw_frame_sync_n_o(raw_n), .inverted_bit_clock_o(inv_clk),
    .read_frame_tick_o(tick), .data_error_i(err_in),
    .data_error_flag_o(err_flag), .jitter_frames_i(jit),
    .buffer_overflow_n_o(ovf_n));
  fslm_far_model #(.FRAME_CYC(FC)) u_far (.clk_i(clk), .en_i(en),
    .drv_i(lock_o), .oe_i(lock_oe), .ext_i(ext), .sync_o(sync_det),
    .bit_clk_o(bclk), .pin_o(pin_lvl), .vpc_o());
  // Compare one observed value with its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One Avalon transfer; the request holds until waitrequest is seen low.
  // A slave that never answers is left to the watchdog to cut short.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rdd);
    @(posedge clk);
    addr <= a;
    wdata <= wd;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rdd = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Bounded wait for the lock indicator to reach a level.
  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (lock_o !== v && n < 600) begin
      @(posedge clk);
      n++;
    end
  endtask
  function automatic logic ovf_exp(input logic signed [7:0] j);
    return j <= 8'sd28 && j >= -8'sd28;
  endfunction
  // Slot A goes out from bit 0, then slot B from bit 47, then zeros.
  function automatic logic slot_bit(input int k);
    if (k < 64) return slot_a[k];
    if (k < 112) return slot_b[111 - k];
    return 1'b0;
  endfunction
  // Main sequence.
  initial begin
    {rst_b, rd, wr, psync, sfil, load, shift, err_in, en, ext} = '0;
    {addr, wdata, jit, slot_a, slot_b} = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    ext <= 1'($random(seed));
    repeat (2) @(posedge clk);
    // Reset value, then unmapped space reads zero and ignores writes.
    bus(1'b0, 4'h0, 32'h0, d);
    check(d, {30'h0, fslm_pkg::CTRL_RESET});
    bus(1'b1, 4'hc, 32'hffff_ffff, d);
    bus(1'b0, 4'hc, 32'h0, d);
    check(d, 32'h0);
    bus(1'b0, 4'h8, 32'h0, d);
    check(d, 32'h0);
    // Handing the lock pin to the outside makes it an input.
    bus(1'b1, 4'h0, 32'hffff_fffd, d);
    bus(1'b0, 4'h0, 32'h0, d);
    check(d, 32'h1);
    bus(1'b0, 4'h4, 32'h0, d);
    check({30'h0, d[1], lock_oe}, {30'h0, ext, 1'b0});
    // Random and boundary traffic through both filter pin selections.
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 4'h0, {30'h0, s[0], 1'b0}, d);
      for (int i = 0; i < 60; i++) begin
        @(posedge clk);
        jit <= (i < 8) ? edges[i] : 8'($random(seed));
        psync <= 1'($random(seed));
        sfil <= 1'($random(seed));
        err_in <= 1'($random(seed));
        @(posedge clk);
        #1;
        check({31'h0, spindle_filter_switch}, {31'h0, s[0] ? psync : sfil});
        check({31'h0, err_flag}, {31'h0, err_in});
        check({31'h0, ovf_n}, {31'h0, ovf_exp(jit)});
      end
    end
    // Load both slots and shift past their end.
    @(posedge clk);
    slot_a <= {$random(seed), $random(seed)};
    slot_b <= 48'({$random(seed), $random(seed)});
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    for (int k = 0; k < 113; k++) begin
      shift <= (k < 112);
      #1;
      check({31'h0, sd}, {31'h0, slot_bit(k)});
      @(posedge clk);
    end
    // Regular syncs lock; losing them needs eight low samples to unlock.
    en <= 1'b1;
    wait_lock(1'b1);
    check({30'h0, lock_oe, lock_o}, 32'h3);
    bus(1'b0, 4'h4, 32'h0, d);
    check({28'h0, d[3:2]}, 32'h1);
    bus(1'b0, 4'h8, 32'h0, d);
    check(d, 32'h0);
    en <= 1'b0;
    repeat (6 * LSC) @(posedge clk);
    check({31'h0, lock_o}, 32'h1);
    bus(1'b0, 4'h4, 32'h0, d);
    check({28'h0, d[3:2]}, 32'h2);
    wait_lock(1'b0);
    check({31'h0, lock_o}, 32'h0);
    en <= 1'b1;
    wait_lock(1'b1);
    check({31'h0, lock_o}, 32'h1);
    bus(1'b0, 4'h8, 32'h0, d);
    check(d, 32'h0);
    end_of_test();
  end
  // Cut a hang short; the whole run needs far fewer cycles.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule
